//--- rtl/cshc_pkg.sv
package cshc_pkg;

  localparam int CNT_W = 12;

  localparam logic [7:0]       SYNC_BYTE   = 8'hE8;
  localparam logic [CNT_W-1:0] SYNC_LAST   = 12'h007;
  localparam logic [CNT_W-1:0] CMD_FIRST   = 12'h008;
  localparam logic [CNT_W-1:0] ALIGN_LAST  = 12'h009;
  localparam logic [CNT_W-1:0] CMD_LAST    = 12'h00D;
  localparam logic [CNT_W-1:0] HEADER_BITS = 12'h018;
  localparam logic [CNT_W-1:0] SHORT_BITS  = 12'h018;
  localparam logic [4:0]       CHUNK_LAST  = 5'h17;
  localparam logic [9:0]       TALLY_MAX   = 10'h3FF;

  localparam int CFG_GLOBAL_QUARTER = 4;
  localparam int CFG_PWM_ENABLE     = 3;
  localparam int CFG_COUNTER_CLEAR  = 2;
  localparam int CFG_WATCHDOG       = 1;
  localparam int CFG_MULTIPLEX      = 0;
  localparam logic [7:0] CFG_RESET  = 8'h00;

  typedef enum logic [1:0] {
    CMD_PWM    = 2'h0,
    CMD_CALIB  = 2'h1,
    CMD_GLOBAL = 2'h2,
    CMD_CONFIG = 2'h3
  } cshc_cmd_t;

  typedef enum logic [1:0] {HUNT, HEADER, PASS} cshc_state_t;

  typedef struct packed {
    cshc_cmd_t   cmd;
    logic [23:0] data;
  } cshc_word_t;

  typedef struct packed {
    logic [1:0]       clkSync;
    logic [1:0]       datSync;
    logic [1:0]       ldSync;
    logic             clkPrev;
    logic             clkOut;
    logic             dinPrev;
    logic             loadPrev;
    cshc_state_t      state;
    logic [7:0]       syncSh;
    logic [CNT_W-1:0] bitCnt;
    logic [CNT_W-1:0] dataLen;
    logic             loadSeen;
    logic [5:0]       cmdSh;
    cshc_cmd_t        cmd;
    logic [9:0]       faultTally;
    logic [23:0]      capSh;
    logic [4:0]       chunkCnt;
    cshc_word_t       word;
    logic             wordValid;
    logic             overrun;
    logic [7:0]       cfgBits;
    logic             counterClear;
    logic             dataOut;
    logic             loadOut;
  } cshc_core_t;

  localparam cshc_core_t CORE_RESET = '0;

endpackage : cshc_pkg

//--- rtl/cshc_buffer.sv
`timescale 1ns/1ns
module cshc_buffer #(
  parameter int WIDTH = 26
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output      logic             inReady,
  output      logic [WIDTH-1:0] outData,
  output      logic             outValid,
  input  wire logic             outReady
);

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0]       cnt;
  } cshc_buf_state_t;

  cshc_buf_state_t s_q;
  cshc_buf_state_t s_d;
  logic            push;
  logic            pop;

  assign inReady  = (s_q.cnt != 2'h2);
  assign outValid = (s_q.cnt != 2'h0);
  assign outData  = s_q.head;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // The head entry is always the oldest word, so the output comes straight from a register.
  always_comb begin
    s_d = s_q;
    unique case (s_q.cnt)
      2'h0: begin
        if (push) begin
          s_d.head = inData;
          s_d.cnt  = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          s_d.head = inData;
        end else if (push) begin
          s_d.tail = inData;
          s_d.cnt  = 2'h2;
        end else if (pop) begin
          s_d.cnt = 2'h0;
        end
      end
      2'h2: begin
        if (pop) begin
          s_d.head = s_q.tail;
          s_d.cnt  = 2'h1;
        end
      end
      default: s_d.cnt = 2'h0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : cshc_buffer

//--- rtl/cshc_header_config.sv
`timescale 1ns/1ns
// Overview of operation
// - Sample data and load on link clock rise; update outputs on that rise.
// - Each transfer is header, then data, then optional tail, in order.
// - Forward header and tail; consume own data share so downstream data shrinks.
// - While load is low, keep hunting the data input for the sync byte.
// - Header is 24 bits: 8 sync, 6 command, 10 fault tally.
// - After sync byte E8, require a load rising edge by bit 9, else resume hunting.
// - Command field is the 2-bit code sent three times.
// - Decoded command sets capture length and destination of captured data.
// - A faulty device adds one to the forwarded fault tally, saturating at 3FF.
// - Command low bit 0 counts overtemperature, 1 counts open LED.
// - Config D4 selects reduced global intensity; resets to zero.
// - Config D3 enables all current drivers; resets to zero.
// - Config D2 clears subframe and PWM counters, then clears itself.
// - Config D1 enables the watchdog; resets to zero.
// - Config D0 enables multiplexed operation; resets to zero.
// - Chain position comes only from data order, no position input.
// - Config byte is sent three times, 24 bits per device.
// - Loaded configuration takes effect at once.
// - Regenerated header starts 25 link clocks after first header bit, short commands.
// - After own capture, later data and tail forwarded one link clock late.
module cshc_header_config #(
  parameter int OUTPUTS = 24,
  parameter int PWM_RES = 12
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                linkClockIn,
  input  wire logic                serialDataIn,
  input  wire logic                loadStrobeIn,
  input  wire logic                overTempFault,
  input  wire logic                openLedFault,
  output      logic                linkClockOut,
  output      logic                serialDataOut,
  output      logic                loadStrobeOut,
  output      logic                globalQuarter,
  output      logic                pwmEnable,
  output      logic                counterClear,
  output      logic                watchdogEnable,
  output      logic                multiplexEnable,
  output      logic                captureOverrun,
  output      cshc_pkg::cshc_word_t capturedWord,
  output      logic                capturedValid,
  input  wire logic                capturedReady
);

  localparam logic [cshc_pkg::CNT_W-1:0] PWM_BITS = cshc_pkg::CNT_W'(OUTPUTS * PWM_RES);

  cshc_pkg::cshc_core_t s_q;
  cshc_pkg::cshc_core_t s_d;
  logic                 bufInReady;

  // Bitwise two-of-three vote over the redundant copies.
  function automatic logic [7:0] vote3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction : vote3

  always_comb begin
    logic                         linkEdge;
    logic                         bitIn;
    logic                         ldIn;
    logic                         ldRise;
    logic [cshc_pkg::CNT_W-1:0]   k;
    logic [cshc_pkg::CNT_W-1:0]   headerIdx;
    logic [7:0]                   cmdVote;
    logic [9:0]                   tallyIn;
    logic                         faultHit;
    logic [23:0]                  capNext;
    logic [7:0]                   cfgVote;
    logic [23:0]                  headerOut;
    linkEdge = 1'b0;
    bitIn    = 1'b0;
    ldIn     = 1'b0;
    ldRise   = 1'b0;
    k        = '0;
    headerIdx = '0;
    cmdVote  = 8'h00;
    tallyIn  = 10'h000;
    faultHit = 1'b0;
    capNext  = 24'h000000;
    cfgVote  = 8'h00;
    headerOut = 24'h000000;

    s_d = s_q;
    s_d.clkSync = {s_q.clkSync[0], linkClockIn};
    s_d.datSync = {s_q.datSync[0], serialDataIn};
    s_d.ldSync  = {s_q.ldSync[0], loadStrobeIn};
    s_d.clkPrev = s_q.clkSync[1];
    // The forwarded clock lags one extra cycle so data has settled before its rising edge.
    s_d.clkOut  = s_q.clkPrev;
    s_d.counterClear = 1'b0;
    if (bufInReady) begin
      s_d.wordValid = 1'b0;
    end

    linkEdge = s_q.clkSync[1] & ~s_q.clkPrev;
    bitIn    = s_q.datSync[1];
    ldIn     = s_q.ldSync[1];
    ldRise   = ldIn & ~s_q.loadPrev;

    if (linkEdge) begin
      s_d.dinPrev  = bitIn;
      s_d.loadPrev = ldIn;
      s_d.syncSh   = {s_q.syncSh[6:0], bitIn};
      unique case (s_q.state)
        cshc_pkg::HUNT: begin
          s_d.dataOut = 1'b0;
          s_d.loadOut = 1'b0;
          // A rise on the last sync bit still counts, so the load level before it is checked.
          if (!s_q.loadPrev && {s_q.syncSh[6:0], bitIn} == cshc_pkg::SYNC_BYTE) begin
            s_d.state      = cshc_pkg::HEADER;
            s_d.bitCnt     = cshc_pkg::SYNC_LAST;
            s_d.loadSeen   = ldRise;
            s_d.chunkCnt   = 5'h00;
            s_d.faultTally = 10'h000;
          end
        end
        cshc_pkg::HEADER: begin
          k = s_q.bitCnt + 12'h001;
          s_d.bitCnt   = k;
          s_d.loadSeen = s_q.loadSeen | ldRise;
          if (k <= cshc_pkg::CMD_LAST) begin
            s_d.cmdSh = {s_q.cmdSh[4:0], bitIn};
          end
          if (k == cshc_pkg::ALIGN_LAST && !(s_q.loadSeen | ldRise)) begin
            s_d.state = cshc_pkg::HUNT;
          end
          if (k == cshc_pkg::CMD_LAST) begin
            // The shifter holds bits 8 to 12 here, oldest in bit 4, so each pair starts on an even bit.
            cmdVote = vote3({6'h00, s_q.cmdSh[4:3]}, {6'h00, s_q.cmdSh[2:1]}, {6'h00, s_q.cmdSh[0], bitIn});
            s_d.cmd = cshc_pkg::cshc_cmd_t'(cmdVote[1:0]);
            if (cmdVote[1:0] == cshc_pkg::CMD_PWM) begin
              s_d.dataLen = s_q.cfgBits[cshc_pkg::CFG_MULTIPLEX] ? (PWM_BITS << 1) : PWM_BITS;
            end else begin
              s_d.dataLen = cshc_pkg::SHORT_BITS;
            end
          end
          if (k > cshc_pkg::CMD_LAST && k < cshc_pkg::HEADER_BITS) begin
            tallyIn = {s_q.faultTally[8:0], bitIn};
            s_d.faultTally = tallyIn;
            if (k == cshc_pkg::HEADER_BITS - 12'h001) begin
              faultHit = s_q.cmd[0] ? openLedFault : overTempFault;
              // The tally saturates rather than wrapping back to a misleading small count.
              if (faultHit && tallyIn != cshc_pkg::TALLY_MAX) begin
                s_d.faultTally = tallyIn + 10'h001;
              end
            end
          end
          // Only the first data set after the header is taken; that is what fixes the position.
          if (k >= cshc_pkg::HEADER_BITS && k < cshc_pkg::HEADER_BITS + s_q.dataLen) begin
            capNext      = {s_q.capSh[22:0], bitIn};
            s_d.capSh    = capNext;
            s_d.chunkCnt = s_q.chunkCnt + 5'h01;
            if (s_q.chunkCnt == cshc_pkg::CHUNK_LAST) begin
              s_d.chunkCnt = 5'h00;
              if (s_q.wordValid && !bufInReady) begin
                s_d.overrun = 1'b1;
              end
              s_d.word      = '{cmd: s_q.cmd, data: capNext};
              s_d.wordValid = 1'b1;
              if (s_q.cmd == cshc_pkg::CMD_CONFIG) begin
                cfgVote = vote3(capNext[23:16], capNext[15:8], capNext[7:0]);
                s_d.cfgBits = {3'h0, cfgVote[4:0]} & ~(8'h01 << cshc_pkg::CFG_COUNTER_CLEAR);
                s_d.counterClear = cfgVote[cshc_pkg::CFG_COUNTER_CLEAR];
              end
            end
          end
          headerOut = {cshc_pkg::SYNC_BYTE, {3{s_q.cmd}}, s_q.faultTally};
          // Own data is swallowed: output idles until the regenerated header begins.
          // The length is stale until the command is decoded, so nothing is sent before that.
          if (k > cshc_pkg::CMD_LAST && k > s_q.dataLen && k <= s_q.dataLen + cshc_pkg::HEADER_BITS) begin
            headerIdx = s_q.dataLen + cshc_pkg::HEADER_BITS - k;
            s_d.dataOut = headerOut[headerIdx[4:0]];
            s_d.loadOut = (k > s_q.dataLen + cshc_pkg::CMD_FIRST);
          end else begin
            s_d.dataOut = 1'b0;
            s_d.loadOut = 1'b0;
          end
          if (k == s_q.dataLen + cshc_pkg::HEADER_BITS) begin
            s_d.state = cshc_pkg::PASS;
          end
        end
        cshc_pkg::PASS: begin
          s_d.dataOut = s_q.dinPrev;
          s_d.loadOut = s_q.loadPrev;
          if (!ldIn) begin
            s_d.state = cshc_pkg::HUNT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= cshc_pkg::CORE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  cshc_buffer #(
    .WIDTH($bits(cshc_pkg::cshc_word_t))
  ) u_buffer (
    .clk      (clk),
    .nrst     (nrst),
    .inData   (s_q.word),
    .inValid  (s_q.wordValid),
    .inReady  (bufInReady),
    .outData  (capturedWord),
    .outValid (capturedValid),
    .outReady (capturedReady)
  );

  assign linkClockOut    = s_q.clkOut;
  assign serialDataOut   = s_q.dataOut;
  assign loadStrobeOut   = s_q.loadOut;
  assign globalQuarter   = s_q.cfgBits[cshc_pkg::CFG_GLOBAL_QUARTER];
  assign pwmEnable       = s_q.cfgBits[cshc_pkg::CFG_PWM_ENABLE];
  assign watchdogEnable  = s_q.cfgBits[cshc_pkg::CFG_WATCHDOG];
  assign multiplexEnable = s_q.cfgBits[cshc_pkg::CFG_MULTIPLEX];
  assign counterClear    = s_q.counterClear;
  assign captureOverrun  = s_q.overrun;

endmodule : cshc_header_config

//--- bench/cshc_header_config_checker.sv
`timescale 1ns/1ns
module cshc_header_config_checker (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 linkClockIn,
  input wire logic                 linkClockOut,
  input wire logic                 serialDataOut,
  input wire logic                 loadStrobeOut,
  input wire logic                 globalQuarter,
  input wire logic                 pwmEnable,
  input wire logic                 counterClear,
  input wire logic                 watchdogEnable,
  input wire logic                 multiplexEnable,
  input wire logic                 captureOverrun,
  input wire cshc_pkg::cshc_word_t capturedWord,
  input wire logic                 capturedValid,
  input wire logic                 capturedReady
);
  logic [2:0] syn;
  logic [2:0] up;
  logic       edgeNow;
  logic [3:0] cfg;
  // Mirrors the two-stage synchroniser so link edges are seen in the same cycle as inside.
  assign edgeNow = syn[1] & ~syn[2];
  assign cfg = {globalQuarter, pwmEnable, watchdogEnable, multiplexEnable};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      {syn, up} <= '0;
    else
      {syn, up} <= {syn[1:0], linkClockIn, up + {2'h0, ~&up}};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_clear_pulse: assert property (counterClear |=> !counterClear)
    else $error("clear pulse too long");
  chk_out_on_edge: assert property (!$stable({serialDataOut, loadStrobeOut}) |-> $past(edgeNow))
    else $error("link output moved off a link edge");
  chk_clock_follow: assert property (&up |-> linkClockOut == $past(linkClockIn, 4))
    else $error("forwarded clock lag wrong");
  chk_cfg_with_word: assert property (!$stable(cfg) |-> ##[0:1] capturedValid)
    else $error("config changed without a word");
  chk_clear_with_word: assert property (counterClear |-> ##[0:1] capturedValid)
    else $error("clear pulse without a word");
  chk_overrun_sticky: assert property (captureOverrun |=> captureOverrun)
    else $error("overrun flag dropped");
  chk_overrun_full: assert property ($rose(captureOverrun) |-> $past(capturedValid))
    else $error("overrun with empty buffer");
  chk_word_hold: assert property (capturedValid && !capturedReady |=> capturedValid && $stable(capturedWord))
    else $error("stalled word lost");
  cover property (counterClear);
  cover property ($rose(captureOverrun));
  cover property ($rose(loadStrobeOut));
endmodule : cshc_header_config_checker

bind cshc_header_config cshc_header_config_checker chk (.clk(clk), .nrst(nrst), .linkClockIn(linkClockIn),
  .linkClockOut(linkClockOut), .serialDataOut(serialDataOut), .loadStrobeOut(loadStrobeOut),
  .globalQuarter(globalQuarter), .pwmEnable(pwmEnable), .counterClear(counterClear),
  .watchdogEnable(watchdogEnable), .multiplexEnable(multiplexEnable), .captureOverrun(captureOverrun),
  .capturedWord(capturedWord), .capturedValid(capturedValid), .capturedReady(capturedReady));

//--- bench/cshc_link_host.sv
`timescale 1ns/1ns
module cshc_link_host (
  output logic linkClock,
  output logic serialData,
  output logic loadStrobe
);
  localparam logic [15:0] TAIL = 16'hC35A;
  initial linkClock = 1'b0;
  initial serialData = 1'b0;
  initial loadStrobe = 1'b0;
  // The link clock runs free, frames or not.
  always #160 linkClock = ~linkClock;
  task automatic sendFrame(input logic [1:0] cmd, input logic [9:0] tally, input logic [7:0] sync,
                           input int n, input logic [23:0] base);
    logic [23:0] header;
    logic [23:0] w;
    int          len;
    header = {sync, {3{cmd}}, tally};
    len = 40 + 24 * n;
    // Data moves on the falling edge, so it is settled around each rising edge.
    for (int i = 0; i < len; i++) begin
      w = i < 24 ? header : base + 24'(i / 24 - 1);
      @(negedge linkClock);
      loadStrobe <= i >= 8;
      serialData <= i < len - 16 ? w[23 - i % 24] : TAIL[len - 1 - i];
    end
    @(negedge linkClock);
    loadStrobe <= 1'b0;
    serialData <= 1'b0;
    repeat (40) @(negedge linkClock);
  endtask : sendFrame
endmodule : cshc_link_host

//--- bench/cascade_serial_header_config_test.sv
`timescale 1ns/1ns
module cascade_serial_header_config_test;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 overTemp = 1'b0;
  logic                 openLed = 1'b0;
  logic                 ready = 1'b0;
  logic                 lcoPrev = 1'b0;
  logic                 lci, sdi, lsi, linkClockOut, serialDataOut, loadStrobeOut;
  logic                 counterClear, captureOverrun, capturedValid;
  logic [3:0]           cfg;
  cshc_pkg::cshc_word_t capturedWord;
  cshc_pkg::cshc_word_t words[$];
  logic [1:0]           outQ[$];
  int                   n_fail = 0, tests_run = 0, nClear = 0, cycles = 0;
  always #20 clk = ~clk;
  cshc_link_host host (.linkClock(lci), .serialData(sdi), .loadStrobe(lsi));
  cshc_header_config dut (.clk(clk), .nrst(nrst), .linkClockIn(lci), .serialDataIn(sdi), .loadStrobeIn(lsi),
    .overTempFault(overTemp), .openLedFault(openLed), .linkClockOut(linkClockOut),
    .serialDataOut(serialDataOut), .loadStrobeOut(loadStrobeOut), .globalQuarter(cfg[3]),
    .pwmEnable(cfg[2]), .counterClear(counterClear), .watchdogEnable(cfg[1]), .multiplexEnable(cfg[0]),
    .captureOverrun(captureOverrun), .capturedWord(capturedWord), .capturedValid(capturedValid),
    .capturedReady(ready));
  always @(posedge clk) begin
    lcoPrev <= linkClockOut;
    cycles <= cycles + 1;
    if (linkClockOut && !lcoPrev)
      outQ.push_back({loadStrobeOut, serialDataOut});
    if (counterClear === 1'b1)
      nClear <= nClear + 1;
    if (capturedValid && ready)
      words.push_back(capturedWord);
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Output entry 2 carries link edge 0, so the first outgoing command bit lands at 35, or 299 after 288 bits.
  task automatic frame(input logic [1:0] flt, input logic [1:0] cmd, input logic [9:0] tally,
                       input logic [9:0] expTally, input logic [7:0] sync, input int n, input logic [23:0] base);
    int          ld;
    logic [39:0] got;
    @(posedge clk);
    {overTemp, openLed} <= flt;
    @(negedge lci);
    outQ.delete();
    host.sendFrame(cmd, tally, sync, n, base);
    ld = -1;
    foreach (outQ[i])
      if (ld < 0 && outQ[i][1])
        ld = i;
    if (sync != 8'hE8) begin
      cmp(ld, -1);
      cmp(words.size(), 0);
    end else begin
      for (int i = 0; i < 40; i++)
        got = {got[38:0], outQ[ld - 8 + i][0]};
      cmp(ld, cmd == 2'h0 ? 299 : 35);
      cmp(got[39:16], {8'hE8, {3{cmd}}, expTally});
      cmp(got[15:0], host.TAIL);
    end
    if (n == 1 && sync == 8'hE8) begin
      cmp(words.size(), 1);
      cmp(words.pop_front(), {cmd, base});
    end
  endtask : frame
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    cmp({cfg, counterClear, capturedValid}, 0);
    frame(2'h2, 2'h0, 10'h000, 10'h001, 8'hE8, 12, 24'h5A0000);
    cmp({capturedValid, captureOverrun, capturedWord}, {2'h3, 2'h0, 24'h5A0000});
    @(posedge clk);
    ready <= 1'b1;
    repeat (4) @(negedge clk);
    // The holding stage keeps only the newest word while both entries are full, so word 11 comes third.
    cmp({words.size(), capturedValid}, {31'h3, 1'b0});
    cmp(words[0], {2'h0, 24'h5A0000});
    cmp(words[2], {2'h0, 24'h5A000B});
    words.delete();
    frame(2'h1, 2'h3, 10'h005, 10'h006, 8'hE8, 1, 24'hFF00FF);
    cmp(cfg, 4'hF);
    cmp(nClear, 1);
    frame(2'h1, 2'h2, 10'h3FE, 10'h3FE, 8'hE8, 1, 24'h123456);
    frame(2'h1, 2'h1, 10'h3FE, 10'h3FF, 8'hE8, 1, 24'hABCDEF);
    cmp(cfg, 4'hF);
    frame(2'h0, 2'h3, 10'h000, 10'h000, 8'hE8, 1, 24'hE90901);
    cmp(cfg, 4'h5);
    cmp(nClear, 1);
    frame(2'h0, 2'h3, 10'h000, 10'h000, 8'hE9, 1, 24'hFFFFFF);
    cmp(cfg, 4'h5);
    wrap_up();
  end
endmodule : cascade_serial_header_config_test
